// ===== core/bst_tap.sv
/*
 * Boundary-scan test access port: instruction register, bypass, boundary
 * register, identification and user signature registers, configuration load.
 * Assumes test pins are asynchronous to sys_clk_in and that the test clock
 * is at most a quarter of the system clock rate.
 */
//
// Overview of operation
// - no boundary scan during configuration
// - sample captures pins, leaves operation alone
// - extest drives pattern, captures input pins
// - bypass is one stage tdi to tdo
// - user_signature shifts user signature out
// - part_identification shifts identification value out
// - configuration load instructions feed configuration logic
// - instruction register is ten bits
// - user signature: seven user, 25 fixed
// - boundary register length is a parameter
// - identification: version, part, maker, one
// - identification lsb is one, shifted first
`timescale 1ns/1ps
module bst_tap
    import bst_pkg::*;
#(
    parameter int                BSR_LEN     = BSR_LEN_DEF,
    parameter logic [IR_LEN-1:0] OPC_EXTEST  = OP_EXTEST,
    parameter logic [IR_LEN-1:0] OPC_SAMPLE  = OP_SAMPLE,
    parameter logic [IR_LEN-1:0] OPC_PART_IDENTIFICATION  = OP_PART_IDENTIFICATION,
    parameter logic [IR_LEN-1:0] OPC_USER    = OP_USER_SIGNATURE,
    parameter logic [IR_LEN-1:0] OPC_CFGLOAD = OP_CFGLOAD,
    parameter logic [IR_LEN-1:0] OPC_BYPASS  = OP_BYPASS
) (
    // clock and reset
    input  wire logic                 sys_clk_in,
    input  wire logic                 rst_in,
    // test port pins
    input  wire logic                 tck_in,
    input  wire logic                 tms_in,
    input  wire logic                 tdi_in,
    output logic                      tdo_out,
    output logic                      tdo_oe_out,
    // device side
    input  wire logic                 config_busy_in,
    input  wire logic [USER_LEN-1:0]  user_code_in,
    input  wire logic [BSR_LEN-1:0]   pin_sample_in,
    output logic      [BSR_LEN-1:0]   pin_drive_out,
    output logic                      extest_active_out,
    // configuration load stream
    output logic                      cfg_active_out,
    output logic                      cfg_data_out,
    output logic                      cfg_strobe_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic               tck_s1_ff, tck_s2_ff, tck_d3_ff;
    logic               tms_s1_ff, tms_s2_ff;
    logic               tdi_s1_ff, tdi_s2_ff;
    logic               busy_s1_ff, busy_s2_ff;
    logic [BSR_LEN-1:0] pin_s1_ff, pin_s2_ff;
    logic               tck_rise, tck_fall;
    bst_state_type      tap_state;
    bst_dr_type         sel;
    logic [IR_LEN-1:0]  ir_shift_ff, ir_ff;
    logic               bypass_ff;
    logic [ID_LEN-1:0]  id_shift_ff;
    logic [BSR_LEN-1:0] bsr_shift_ff, bsr_upd_ff;
    logic               tdo_ff, tdo_oe_ff;
    logic               extest_ff, cfg_active_ff, cfg_data_ff, cfg_strobe_ff;
    logic [ID_LEN-1:0]  part_identification_val;
    logic [ID_LEN-1:0]  user_signature_val;
    logic               cap_dr, shift_dr, upd_dr;

    // identification word, msb first: version, part, maker, fixed one
    assign part_identification_val   = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
    assign user_signature_val = {USER_FIXED, user_code_in};

    // ****************************************************************
    // pin synchronisers and test-clock edge detection
    // ****************************************************************
    // two stages on every pin; only the second stage is looked at, except tck, whose third stage is compared with it for edges
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tck_s1_ff  <= 1'b0;
            tck_s2_ff  <= 1'b0;
            tck_d3_ff  <= 1'b0;
            tms_s1_ff  <= 1'b1;
            tms_s2_ff  <= 1'b1;
            tdi_s1_ff  <= 1'b1;
            tdi_s2_ff  <= 1'b1;
            busy_s1_ff <= 1'b0;
            busy_s2_ff <= 1'b0;
        end else begin
            tck_s1_ff  <= tck_in;
            tck_s2_ff  <= tck_s1_ff;
            tck_d3_ff  <= tck_s2_ff;
            tms_s1_ff  <= tms_in;
            tms_s2_ff  <= tms_s1_ff;
            tdi_s1_ff  <= tdi_in;
            tdi_s2_ff  <= tdi_s1_ff;
            busy_s1_ff <= config_busy_in;
            busy_s2_ff <= busy_s1_ff;
        end
    end

    // device pins sampled for the boundary register, wide but cheap
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= pin_sample_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign tck_rise = tck_s2_ff & ~tck_d3_ff;
    assign tck_fall = ~tck_s2_ff & tck_d3_ff;

    bst_tap_fsm u_fsm (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .step_in    (tck_rise),
        .tms_in     (tms_s2_ff),
        .state_out  (tap_state)
    );

    assign cap_dr   = tck_rise && (tap_state == ST_CAP_DR);
    assign shift_dr = tck_rise && (tap_state == ST_SHIFT_DR);
    assign upd_dr   = tck_rise && (tap_state == ST_UPD_DR);

    // ****************************************************************
    // instruction decode
    // ****************************************************************
    // extest and sample fall back to bypass while configuration runs
    function automatic bst_dr_type dr_select(input logic [IR_LEN-1:0] ir,
                                             input logic busy);
        if (ir == OPC_EXTEST) begin
            dr_select = busy ? DR_BYPASS : DR_EXTEST;
        end else if (ir == OPC_SAMPLE) begin
            dr_select = busy ? DR_BYPASS : DR_SAMPLE;
        end else if (ir == OPC_PART_IDENTIFICATION) begin
            dr_select = DR_ID;
        end else if (ir == OPC_USER) begin
            dr_select = DR_USER;
        end else if (ir == OPC_CFGLOAD) begin
            dr_select = DR_CFG;
        end else begin
            dr_select = DR_BYPASS;
        end
    endfunction

    assign sel = dr_select(ir_ff, busy_s2_ff);

    // ****************************************************************
    // instruction register
    // ****************************************************************
    // update takes effect on the rising edge that leaves update-ir
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ir_shift_ff <= IR_CAPTURE;
            ir_ff       <= IR_RESET;
        end else if (tck_rise) begin
            case (tap_state)
                ST_RESET:    ir_ff       <= IR_RESET;
                ST_CAP_IR:   ir_shift_ff <= IR_CAPTURE;
                ST_SHIFT_IR: ir_shift_ff <= {tdi_s2_ff, ir_shift_ff[IR_LEN-1:1]};
                ST_UPD_IR:   ir_ff       <= ir_shift_ff;
                default:     ir_ff       <= ir_ff;
            endcase
        end
    end

    // ****************************************************************
    // data registers
    // ****************************************************************
    // one-stage path, shared by bypass and configuration load
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bypass_ff <= 1'b0;
        end else if (cap_dr) begin
            bypass_ff <= 1'b0;
        end else if (shift_dr && (sel == DR_BYPASS || sel == DR_CFG)) begin
            bypass_ff <= tdi_s2_ff;
        end
    end

    // identification and user signature share one 32-bit shifter
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            id_shift_ff <= '0;
        end else if (cap_dr && sel == DR_ID) begin
            id_shift_ff <= part_identification_val;
        end else if (cap_dr && sel == DR_USER) begin
            id_shift_ff <= user_signature_val;
        end else if (shift_dr && (sel == DR_ID || sel == DR_USER)) begin
            id_shift_ff <= {tdi_s2_ff, id_shift_ff[ID_LEN-1:1]};
        end
    end

    // boundary register: capture pins, shift, then hold pattern for the pins
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            bsr_shift_ff <= '0;
            bsr_upd_ff   <= '0;
        end else if (sel == DR_SAMPLE || sel == DR_EXTEST) begin
            if (cap_dr) begin
                bsr_shift_ff <= pin_s2_ff;
            end else if (shift_dr) begin
                bsr_shift_ff <= {tdi_s2_ff, bsr_shift_ff[BSR_LEN-1:1]};
            end else if (upd_dr) begin
                bsr_upd_ff   <= bsr_shift_ff;
            end
        end
    end

    // pins follow the pattern only under extest, so sample stays quiet
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            extest_ff <= 1'b0;
        end else begin
            extest_ff <= (sel == DR_EXTEST);
        end
    end

    // ****************************************************************
    // configuration load stream
    // ****************************************************************
    // each shifted bit goes to the configuration logic as one strobe
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            cfg_active_ff <= 1'b0;
            cfg_data_ff   <= 1'b0;
            cfg_strobe_ff <= 1'b0;
        end else begin
            cfg_active_ff <= (sel == DR_CFG);
            cfg_strobe_ff <= shift_dr && (sel == DR_CFG);
            if (shift_dr && sel == DR_CFG) begin
                cfg_data_ff <= tdi_s2_ff;
            end
        end
    end

    // ****************************************************************
    // serial output, changed on the falling test-clock edge
    // ****************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_ff <= bst_is_shift(tap_state);
            if (tap_state == ST_SHIFT_IR) begin
                tdo_ff <= ir_shift_ff[0];
            end else if (tap_state != ST_SHIFT_DR) begin
                tdo_ff <= 1'b0;
            end else if (sel == DR_ID || sel == DR_USER) begin
                tdo_ff <= id_shift_ff[0];
            end else if (sel == DR_SAMPLE || sel == DR_EXTEST) begin
                tdo_ff <= bsr_shift_ff[0];
            end else begin
                tdo_ff <= bypass_ff;
            end
        end
    end

    assign tdo_out           = tdo_ff;
    assign tdo_oe_out        = tdo_oe_ff;
    assign pin_drive_out     = bsr_upd_ff;
    assign extest_active_out = extest_ff;
    assign cfg_active_out    = cfg_active_ff;
    assign cfg_data_out      = cfg_data_ff;
    assign cfg_strobe_out    = cfg_strobe_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence id_captured;
        tck_rise && tap_state == ST_CAP_DR && sel == DR_ID && !tms_s2_ff;
    endsequence

    sequence next_fall_shows_one;
        ##[1:8] tck_fall ##1 (tdo_ff && tdo_oe_ff);
    endsequence

    id_capture_a: assert property (id_captured |=> id_shift_ff == part_identification_val)
        else $error("identification value not captured");
    id_first_one_a: assert property (id_captured |-> next_fall_shows_one)
        else $error("first identification bit on tdo is not one");
    user_capture_a: assert property ((cap_dr && sel == DR_USER)
        |=> id_shift_ff == {USER_FIXED, $past(user_code_in)})
        else $error("user signature not captured");
    user_shift_a: assert property ((tck_fall && tap_state == ST_SHIFT_DR && sel == DR_USER)
        |=> tdo_ff == $past(id_shift_ff[0]))
        else $error("user signature bit not on tdo");
    bypass_path_a: assert property ((tck_fall && tap_state == ST_SHIFT_DR
        && sel == DR_BYPASS) |=> tdo_oe_ff && tdo_ff == $past(bypass_ff))
        else $error("bypass stage not on tdo");
    tdo_release_a: assert property ((tck_fall && !bst_is_shift(tap_state))
        |=> !tdo_oe_ff)
        else $error("tdo driven outside shift states");
    ir_capture_a: assert property ((tck_rise && tap_state == ST_CAP_IR)
        |=> ir_shift_ff == IR_CAPTURE)
        else $error("instruction capture pattern wrong");
    extest_drive_a: assert property ((sel == DR_EXTEST) |=> extest_ff)
        else $error("extest did not take the pins");
    sample_quiet_a: assert property ((sel == DR_SAMPLE) |=> !extest_ff)
        else $error("sample disturbed the pins");
    config_block_a: assert property (busy_s2_ff |=> !extest_ff && sel != DR_SAMPLE)
        else $error("boundary scan active during configuration");
    bsr_capture_a: assert property ((cap_dr && sel == DR_EXTEST)
        |=> bsr_shift_ff == $past(pin_s2_ff))
        else $error("boundary register did not capture pins");
    unknown_op_a: assert property ((ir_ff != OPC_EXTEST && ir_ff != OPC_SAMPLE
        && ir_ff != OPC_PART_IDENTIFICATION && ir_ff != OPC_USER && ir_ff != OPC_CFGLOAD)
        |-> sel == DR_BYPASS)
        else $error("unknown instruction did not select bypass");
    cfg_strobe_a: assert property (cfg_strobe_ff |-> cfg_active_ff
        && cfg_data_out == $past(tdi_s2_ff))
        else $error("configuration strobe outside load instruction");

endmodule

// ===== core/bst_pkg.sv
/*
 * Shared constants and types for the boundary-scan test access port.
 * Assumes one system clock that is fast enough to oversample the test clock.
 */
package bst_pkg;

    // ****************************************************************
    // register lengths and field widths
    // ****************************************************************
    localparam int IR_LEN       = 10;
    localparam int ID_LEN       = 32;
    localparam int USER_LEN     = 7;
    localparam int USER_FIX_LEN = 25;
    localparam int BSR_LEN_DEF  = 690;

    // ****************************************************************
    // instruction encodings (defaults for the module parameters)
    // ****************************************************************
    localparam logic [IR_LEN-1:0] OP_EXTEST   = 10'h000;
    localparam logic [IR_LEN-1:0] OP_CFGLOAD  = 10'h002;
    localparam logic [IR_LEN-1:0] OP_SAMPLE   = 10'h005;
    localparam logic [IR_LEN-1:0] OP_PART_IDENTIFICATION   = 10'h006;
    localparam logic [IR_LEN-1:0] OP_USER_SIGNATURE = 10'h007;
    localparam logic [IR_LEN-1:0] OP_BYPASS   = 10'h3ff;
    localparam logic [IR_LEN-1:0] IR_CAPTURE  = 10'h001;
    localparam logic [IR_LEN-1:0] IR_RESET    = OP_PART_IDENTIFICATION;

    // ****************************************************************
    // identification and signature values (arbitrary neutral values)
    // ****************************************************************
    localparam logic [3:0]  ID_VERSION = 4'ha;
    localparam logic [15:0] ID_PART    = 16'h5a5a;
    localparam logic [10:0] ID_MAKER   = 11'h2c3;
    localparam logic        ID_LSB     = 1'b1;
    localparam logic [USER_FIX_LEN-1:0] USER_FIXED = 25'h0_1234;

    // ****************************************************************
    // controller states, gray-coded along the usual path
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SHIFT_DR = 4'h6,
        ST_EX1_DR   = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EX2_DR   = 4'h4,
        ST_UPD_DR   = 4'hc,
        ST_SEL_IR   = 4'hd,
        ST_CAP_IR   = 4'hf,
        ST_SHIFT_IR = 4'he,
        ST_EX1_IR   = 4'ha,
        ST_PAUSE_IR = 4'hb,
        ST_EX2_IR   = 4'h9,
        ST_UPD_IR   = 4'h8
    } bst_state_type;

    // data register selected between serial input and output
    typedef enum logic [2:0] {
        DR_BYPASS = 3'h0,
        DR_SAMPLE = 3'h1,
        DR_EXTEST = 3'h2,
        DR_ID     = 3'h3,
        DR_USER   = 3'h4,
        DR_CFG    = 3'h5
    } bst_dr_type;

    // true in the two states where the serial output is driven
    function automatic logic bst_is_shift(input bst_state_type st);
        bst_is_shift = (st == ST_SHIFT_DR) || (st == ST_SHIFT_IR);
    endfunction

endpackage

// ===== core/bst_tap_fsm.sv
/*
 * Sixteen-state test access port controller.
 * Assumes step_in is a one-cycle pulse on each rising test-clock edge and
 * that tms_in is already synchronised to sys_clk_in.
 */
`timescale 1ns/1ps
module bst_tap_fsm
    import bst_pkg::*;
(
    // clock and reset
    input  wire logic          sys_clk_in,
    input  wire logic          rst_in,
    // test-clock step and mode select
    input  wire logic          step_in,
    input  wire logic          tms_in,
    // controller state
    output bst_state_type      state_out
);

    bst_state_type state_ff;
    bst_state_type nxt_state;

    // ****************************************************************
    // next state, taken only on a test-clock rising edge
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RESET:    nxt_state = tms_in ? ST_RESET    : ST_IDLE;
            ST_IDLE:     nxt_state = tms_in ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   nxt_state = tms_in ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   nxt_state = tms_in ? ST_EX1_DR   : ST_SHIFT_DR;
            ST_SHIFT_DR: nxt_state = tms_in ? ST_EX1_DR   : ST_SHIFT_DR;
            ST_EX1_DR:   nxt_state = tms_in ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: nxt_state = tms_in ? ST_EX2_DR   : ST_PAUSE_DR;
            ST_EX2_DR:   nxt_state = tms_in ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   nxt_state = tms_in ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_IR:   nxt_state = tms_in ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   nxt_state = tms_in ? ST_EX1_IR   : ST_SHIFT_IR;
            ST_SHIFT_IR: nxt_state = tms_in ? ST_EX1_IR   : ST_SHIFT_IR;
            ST_EX1_IR:   nxt_state = tms_in ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: nxt_state = tms_in ? ST_EX2_IR   : ST_PAUSE_IR;
            ST_EX2_IR:   nxt_state = tms_in ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   nxt_state = tms_in ? ST_SEL_DR   : ST_IDLE;
            default:     nxt_state = ST_RESET;
        endcase
    end

    // state register; five tms-high steps always reach reset
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_ff <= ST_RESET;
        end else if (step_in) begin
            state_ff <= nxt_state;
        end
    end

    assign state_out = state_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    reset_exit_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (step_in && tms_in && state_ff == ST_SEL_IR) |=> state_ff == ST_RESET)
        else $error("select-ir with tms high did not enter reset");

endmodule

// ===== bench/bst_ctl_model.sv
/*
 * Model of the external test controller: it makes the test clock and drives
 * the mode select and serial data in, and it reads the serial output.
 * Assumes the testbench resolves the serial output wire with its pull-up.
 */
`timescale 1ns/1ps
module bst_ctl_model (
    // test port
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out,
    input  wire logic tdo_in
);
    // ****************************************************************
    // serial steps
    // ****************************************************************
    // test clock stands low between frames
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end

    // one 200 ns period; the output is read late in the high phase, well
    // after the device presented it on the previous fall
    task automatic step(input logic ms, input logic di, output logic so);
        tms_out = ms;
        tdi_out = di;
        #100 tck_out = 1'b1;
        #95 so = tdo_in;
        #5 tck_out = 1'b0;
    endtask

    // idle, select, capture, shift exactly n bits lsb first, update, idle
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic b;
        dout = 64'h0;
        step(1'b0, 1'b0, b);
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule

// ===== bench/tb.sv
/*
 * Self-checking testbench for the boundary-scan test access port.
 * Assumes the controller model above; the serial output has a weak pull-up.
 */
`timescale 1ns/1ps
module tb;
    import bst_pkg::*;
    localparam int BSR = 8;
    logic           sys_clk = 1'b0;
    logic           rst = 1'b1;
    logic           busy = 1'b0;
    logic           tck, tms, tdi, tdo, tdo_oe, tdo_wire, ext, cact, cdat, cstb;
    logic [6:0]     ucode = 7'h5b;
    logic [BSR-1:0] pins = 8'ha5;
    logic [BSR-1:0] drive;
    logic [63:0]    d;
    int             errors = 0;
    int             compares = 0;
    int             nstb = 0;

    // ****************************************************************
    // clock, wire and instances
    // ****************************************************************
    always #12.5 sys_clk = ~sys_clk;
    assign tdo_wire = tdo_oe ? tdo : 1'b1; // released line floats high
    // count configuration strobes to prove one per shifted bit
    always @(posedge sys_clk) if (cstb === 1'b1) nstb <= nstb + 1;

    bst_tap #(.BSR_LEN(BSR)) i_dut (
        .sys_clk_in(sys_clk), .rst_in(rst), .tck_in(tck), .tms_in(tms),
        .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .config_busy_in(busy), .user_code_in(ucode), .pin_sample_in(pins),
        .pin_drive_out(drive), .extest_active_out(ext),
        .cfg_active_out(cact), .cfg_data_out(cdat), .cfg_strobe_out(cstb));
    bst_ctl_model i_ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
                         .tdo_in(tdo_wire));

    // ****************************************************************
    // checks and scenarios
    // ****************************************************************
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic load(input logic [IR_LEN-1:0] op);
        i_ctl.scan(1'b1, IR_LEN, 64'(op), d);
        chk(64'(d[IR_LEN-1:0]), 64'(IR_CAPTURE));
    endtask
    task automatic scan8(input logic [7:0] din, input logic [7:0] exp);
        i_ctl.scan(1'b0, BSR, 64'(din), d);
        chk(64'(d[7:0]), 64'(exp));
    endtask
    task automatic t_id();
        i_ctl.scan(1'b0, 32, 64'h0, d);
        chk(64'(d[31:0]), 64'({ID_VERSION, ID_PART, ID_MAKER, ID_LSB}));
        chk(64'(tdo_oe), 64'h0);
    endtask
    task automatic t_user();
        load(OP_USER_SIGNATURE);
        i_ctl.scan(1'b0, 32, 64'h0, d);
        chk(64'(d[31:0]), 64'({USER_FIXED, ucode}));
    endtask
    task automatic t_bypass();
        load(10'h155);
        scan8(8'h96, 8'h2c);
        load(OP_BYPASS);
        scan8(8'h96, 8'h2c);
    endtask
    task automatic t_scan_pins();
        load(OP_EXTEST);
        chk(64'(ext), 64'h1);
        scan8(8'hc3, 8'ha5);
        chk(64'(drive), 64'hc3);
        @(posedge sys_clk) #2 pins = 8'h5a;
        load(OP_SAMPLE);
        chk(64'(ext), 64'h0);
        scan8(8'h3c, 8'h5a);
        chk(64'(drive), 64'h3c);
    endtask
    task automatic t_busy();
        @(posedge sys_clk) #2 busy = 1'b1;
        load(OP_EXTEST);
        chk(64'(ext), 64'h0);
        scan8(8'hff, 8'hfe);
        @(posedge sys_clk) #2 busy = 1'b0;
    endtask
    task automatic t_cfg();
        int n0;
        load(OP_CFGLOAD);
        chk(64'(cact), 64'h1);
        n0 = nstb;
        i_ctl.scan(1'b0, 8, 64'h81, d);
        chk(64'(nstb - n0), 64'h8);
        chk(64'(cdat), 64'h1);
        chk(64'(d[7:1]), 64'h1);
    endtask
    task automatic t_tlr();
        logic b;
        repeat (5) i_ctl.step(1'b1, 1'b0, b);
        t_id();
    endtask
    // mid-run system reset: outputs clear and the instruction returns to identification
    task automatic t_rst();
        @(posedge sys_clk) #2 rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #2 rst = 1'b0;
        chk(64'({drive, ext, cact, tdo_oe}), 64'h0);
        repeat (3) @(posedge sys_clk);
        #2;
        t_id();
    endtask

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (5) @(posedge sys_clk);
        #2 rst = 1'b0;
        repeat (3) @(posedge sys_clk);
        // keep every test-pin change off the system clock edge
        #2;
        t_id();
        t_user();
        t_bypass();
        t_scan_pins();
        t_busy();
        t_cfg();
        t_rst();
        t_tlr();
        results();
    end
    // about 360 test-clock periods are needed; allow 1000
    initial begin
        #200000;
        errors++;
        results();
    end
endmodule
